// ### include/gpev_consts.svh
`ifndef GPEV_CONSTS_SVH
`define GPEV_CONSTS_SVH
// register offsets (byte addresses in configuration space)
`define GPEV_OFS_PM_DATA   8'hA7
`define GPEV_OFS_STATUS    8'hA8
`define GPEV_OFS_ENABLE    8'hAA
`define GPEV_OFS_INPUT     8'hAC
`define GPEV_OFS_TERM_CFG  8'hB8
// field positions
`define GPEV_BIT_VIDEO     15
`define GPEV_BIT_POWER     11
`define GPEV_BIT_PROG12    8
// implemented bits of status and enable
`define GPEV_EVENT_MASK    16'h8_91F
// reset values
`define GPEV_RST_STATUS    16'h0000
`define GPEV_RST_ENABLE    16'h0000
`define GPEV_RST_PM_DATA   8'h00
`define GPEV_RST_TERM_CFG  16'h0000
`endif

// ### include/gpev_pkg.sv
package gpev_pkg;
    typedef logic [15:0] gpev_word_type;
    typedef logic [4:0]  gpev_inputs_type;
    typedef enum logic [1:0] {
        GPEV_OUT_IDLE,
        GPEV_OUT_ASSERTED
    } gpev_out_state_type;
endpackage : gpev_pkg

// ### include/gpev_event_if.sv
`timescale 1ns/1ps
// event carrier between the event core and the register decode
interface gpev_event_if;
    logic [15:0] set_vec;    // one-cycle event pulses per status bit
    logic [15:0] clr_vec;    // write-one-to-clear pulses per status bit
    logic [15:0] status;     // current sticky flags
    modport core (input set_vec, input clr_vec, output status);
    modport src  (output set_vec, output clr_vec, input status);
endinterface : gpev_event_if

// ### design/gpev_in_sync.sv
`timescale 1ns/1ps
`include "gpev_consts.svh"
// two-stage synchroniser plus change detector for the input terminals
module gpev_in_sync
    import gpev_pkg::*;
#(
    parameter int WIDTH = 5
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             clk_en_i,
    // terminals and results
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] change_o
);
    logic [WIDTH-1:0] meta_reg;   // first stage, read only by second stage
    logic [WIDTH-1:0] sync_reg;   // settled level
    logic [WIDTH-1:0] last_reg;   // level one cycle earlier
    logic [1:0]       prime_cnt_reg; // fill edges seen; the chain holds reset zeros until 3

    // one generate loop: each bit is its own synchroniser chain
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                meta_reg[i] <= 1'b0;
                sync_reg[i] <= 1'b0;
                last_reg[i] <= 1'b0;
            end else if (clk_en_i) begin
                meta_reg[i] <= pin_i[i];
                sync_reg[i] <= meta_reg[i];
                last_reg[i] <= sync_reg[i];
            end
        end
        // one transition gives exactly one pulse
        assign change_o[i] = (prime_cnt_reg == 2'h3) & (sync_reg[i] ^ last_reg[i]);
    end

    // wait three enabled edges so a terminal held high is not seen as a change
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prime_cnt_reg <= 2'h0;
        end else if (clk_en_i && (prime_cnt_reg != 2'h3)) begin
            prime_cnt_reg <= prime_cnt_reg + 2'h1;
        end
    end

    assign level_o = sync_reg;
endmodule : gpev_in_sync

// ### design/gpev_flags.sv
`timescale 1ns/1ps
`include "gpev_consts.svh"
// sticky status flags: set wins over clear
module gpev_flags
    import gpev_pkg::*;
(
    // clock and reset
    input  wire logic  sys_clk_i,
    input  wire logic  rst_n_i,
    input  wire logic  clk_en_i,
    // flag traffic
    gpev_event_if.core ev
);
    gpev_word_type status_reg;   // sticky flags
    gpev_word_type status_next;  // next value

    // set regardless of enable, cleared by ones, reserved forced low
    assign status_next = ((status_reg & ~ev.clr_vec) | ev.set_vec)
                         & `GPEV_EVENT_MASK;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_reg <= `GPEV_RST_STATUS;
        end else if (clk_en_i) begin
            status_reg <= status_next;
        end
    end

    assign ev.status = status_reg;

    a_set_wins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        clk_en_i && (ev.set_vec[0] || ev.set_vec[15]) |=>
        (status_reg[0] || !$past(ev.set_vec[0])) && (status_reg[15] || !$past(ev.set_vec[15])))
        else $error("event flag lost on set");
    a_clear_one: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        clk_en_i && ev.clr_vec[11] && !ev.set_vec[11] |=> !status_reg[11])
        else $error("flag not cleared by one");
    a_rsvd_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (status_reg & ~`GPEV_EVENT_MASK) == 16'h0000)
        else $error("reserved status bit set");
endmodule : gpev_flags

// ### design/gpev_core.sv
`timescale 1ns/1ps
`include "gpev_consts.svh"
module gpev_core
    import gpev_pkg::*;
#(
    parameter int NUM_INPUTS = 5
) (
    // clock, enable, reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  clk_en_i,
    input  wire logic                  rst_n_i,
    // register port
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [15:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [15:0]           reg_rdata_o,
    // socket condition inputs
    input  wire logic                  video_port_enable_i,
    input  wire logic [3:0]            socket_vcc_sel_i,
    input  wire logic [3:0]            socket_vpp_sel_i,
    input  wire logic                  vpp_is_12v_i,
    // input terminals
    input  wire logic [NUM_INPUTS-1:0] input_pins_i,
    // event output
    output logic                       general_event_out_n_o
);
    // reset release chain: async assert, sync deassert
    logic          rst_meta_reg;      // first stage, read only by second
    logic          rst_sync_reg;      // reset seen by the rest of the block
    // register state
    gpev_word_type enable_reg;        // event enable mask
    gpev_word_type term_cfg_reg;      // terminal function configuration
    gpev_word_type rdata_reg;         // read data, valid cycle after strobe
    gpev_word_type rdata_next;        // next read data
    logic          out_n_reg;         // event output, active low
    gpev_out_state_type out_state_reg;  // output state
    gpev_out_state_type out_state_next; // next output state
    // previous condition samples for change detection
    logic          video_last_reg;
    logic [3:0]    vcc_last_reg;
    logic [3:0]    vpp_last_reg;
    logic          prog12_last_reg;
    logic          cond_primed_reg;   // suppresses edges right after reset

    // synchronised terminals
    logic [NUM_INPUTS-1:0] in_level;  // settled terminal levels
    logic [NUM_INPUTS-1:0] in_change; // one-cycle change pulses

    // decode wires
    wire wr_status  = reg_wr_i && (reg_addr_i == `GPEV_OFS_STATUS);
    wire wr_enable  = reg_wr_i && (reg_addr_i == `GPEV_OFS_ENABLE);
    wire wr_termcfg = reg_wr_i && (reg_addr_i == `GPEV_OFS_TERM_CFG);
    wire sel_pm     = (reg_addr_i == `GPEV_OFS_PM_DATA);
    wire sel_status = (reg_addr_i == `GPEV_OFS_STATUS);
    wire sel_enable = (reg_addr_i == `GPEV_OFS_ENABLE);
    wire sel_input  = (reg_addr_i == `GPEV_OFS_INPUT);
    wire sel_cfg    = (reg_addr_i == `GPEV_OFS_TERM_CFG);

    // condition change pulses
    wire video_chg  = cond_primed_reg && (video_port_enable_i != video_last_reg);
    wire power_chg  = cond_primed_reg && ((socket_vcc_sel_i != vcc_last_reg)
                                       || (socket_vpp_sel_i != vpp_last_reg));
    wire prog12_chg = cond_primed_reg && (vpp_is_12v_i != prog12_last_reg);

    // terminal configuration fields: low bits say input function per terminal,
    // bit 15 says a terminal carries the event output
    wire [NUM_INPUTS-1:0] term_is_input = term_cfg_reg[NUM_INPUTS-1:0];
    wire                  event_routed  = term_cfg_reg[15];

    gpev_event_if ev ();

    // per-event set vector
    gpev_word_type set_vec;
    always_comb begin
        set_vec = 16'h0000;
        set_vec[`GPEV_BIT_VIDEO]  = video_chg;
        set_vec[`GPEV_BIT_POWER]  = power_chg;
        set_vec[`GPEV_BIT_PROG12] = prog12_chg;
        set_vec[NUM_INPUTS-1:0]   = in_change;
    end
    assign ev.set_vec = set_vec;
    // write one clears, write zero keeps
    assign ev.clr_vec = wr_status ? reg_wdata_i : 16'h0000;

    // enabled events; input events also need the input function
    gpev_word_type gate_vec;
    always_comb begin
        gate_vec = enable_reg;
        gate_vec[NUM_INPUTS-1:0] = enable_reg[NUM_INPUTS-1:0] & term_is_input;
    end
    wire pending = |(ev.status & gate_vec);

    // read mux; pm data byte is always zero
    always_comb begin
        rdata_next = 16'h0000;
        if (sel_pm) begin
            rdata_next = {8'h00, `GPEV_RST_PM_DATA};
        end else if (sel_status) begin
            rdata_next = ev.status;
        end else if (sel_enable) begin
            rdata_next = enable_reg;
        end else if (sel_input) begin
            rdata_next = {{(16-NUM_INPUTS){1'b0}}, in_level};
        end else if (sel_cfg) begin
            rdata_next = term_cfg_reg;
        end
    end

    // output state machine: asserted while a routed enabled flag stands
    always_comb begin
        case (out_state_reg)
            GPEV_OUT_IDLE:     out_state_next = (pending && event_routed)
                                                ? GPEV_OUT_ASSERTED : GPEV_OUT_IDLE;
            GPEV_OUT_ASSERTED: out_state_next = (pending && event_routed)
                                                ? GPEV_OUT_ASSERTED : GPEV_OUT_IDLE;
            default:           out_state_next = GPEV_OUT_IDLE;
        endcase
    end

    gpev_in_sync #(
        .WIDTH    (NUM_INPUTS)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i  (rst_sync_reg),
        .clk_en_i (clk_en_i),
        .pin_i    (input_pins_i),
        .level_o  (in_level),
        .change_o (in_change)
    );

    gpev_flags u_flags (
        .sys_clk_i(sys_clk_i),
        .rst_n_i  (rst_sync_reg),
        .clk_en_i (clk_en_i),
        .ev       (ev.core)
    );

    // reset release; runs without the enable so reset always completes
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // software registers; reserved enable bits never store
    always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            enable_reg   <= `GPEV_RST_ENABLE;
            term_cfg_reg <= `GPEV_RST_TERM_CFG;
        end else if (clk_en_i) begin
            if (wr_enable) begin
                enable_reg <= reg_wdata_i & `GPEV_EVENT_MASK;
            end
            if (wr_termcfg) begin
                term_cfg_reg <= reg_wdata_i;
            end
        end
    end

    // condition history for change detection
    always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            video_last_reg  <= 1'b0;
            vcc_last_reg    <= 4'h0;
            vpp_last_reg    <= 4'h0;
            prog12_last_reg <= 1'b0;
            cond_primed_reg <= 1'b0;
        end else if (clk_en_i) begin
            video_last_reg  <= video_port_enable_i;
            vcc_last_reg    <= socket_vcc_sel_i;
            vpp_last_reg    <= socket_vpp_sel_i;
            prog12_last_reg <= vpp_is_12v_i;
            cond_primed_reg <= 1'b1;
        end
    end

    // read data and output; read data loaded on a read strobe, zeroed on any other enabled edge
    always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rdata_reg     <= 16'h0000;
            out_state_reg <= GPEV_OUT_IDLE;
            out_n_reg     <= 1'b1;
        end else if (clk_en_i) begin
            rdata_reg     <= reg_rd_i ? rdata_next : 16'h0000;
            out_state_reg <= out_state_next;
            out_n_reg     <= (out_state_next != GPEV_OUT_ASSERTED);
        end
    end

    assign reg_rdata_o           = rdata_reg;
    assign general_event_out_n_o = out_n_reg;

    a_pm_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && reg_rd_i && sel_pm |=> reg_rdata_o == 16'h0000)
        else $error("pm data read not zero");
    a_input_read: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && reg_rd_i && sel_input |=> reg_rdata_o[15:NUM_INPUTS] == '0)
        else $error("input register upper bits not zero");
    a_video_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && video_chg |=> ev.status[15])
        else $error("video change not flagged");
    a_power_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && power_chg |=> ev.status[11])
        else $error("power change not flagged");
    a_prog12_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && prog12_chg |=> ev.status[8])
        else $error("12 V change not flagged");
    a_input_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && in_change[0] |=> ev.status[0])
        else $error("terminal change not flagged");
    sequence s_enabled_event;
        clk_en_i && event_routed && enable_reg[11] && power_chg;
    endsequence
    sequence s_output_low;
        clk_en_i [*1] ##0 !general_event_out_n_o;
    endsequence
    a_out_assert: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        s_enabled_event ##1 (clk_en_i && event_routed && enable_reg[11]
                             && !wr_status) |=> s_output_low)
        else $error("enabled event did not assert output");
    a_out_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && !general_event_out_n_o && pending && event_routed && !wr_status
        && !wr_enable && !wr_termcfg |=> !general_event_out_n_o)
        else $error("output dropped without clear");
    a_out_routed: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && !event_routed |=> general_event_out_n_o)
        else $error("output driven while not routed");
    // terminal 0 flagged and enabled but not an input: only other flags may drive the output
    a_in_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && enable_reg[0] && ev.status[0] && !term_is_input[0]
        && ((ev.status & enable_reg & 16'h8_91E) == 16'h0000) |=> general_event_out_n_o)
        else $error("input event not gated by function");

    // reserved enable bits never hold a one
    a_enable_rsvd: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        (enable_reg & ~`GPEV_EVENT_MASK) == 16'h0000)
        else $error("reserved enable bit set");

    // enable write keeps only implemented bits
    a_enable_write: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && wr_enable |=> enable_reg == ($past(reg_wdata_i) & `GPEV_EVENT_MASK))
        else $error("enable write not stored");

    // read data is zero in any cycle not following a read
    a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data without read strobe");

    // unmapped offsets read back zero
    a_unmapped_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && reg_rd_i && !(sel_pm || sel_status || sel_enable || sel_input || sel_cfg)
        |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");

    // status read returns the flags as they stood at the strobe
    a_status_read: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && reg_rd_i && sel_status |=> reg_rdata_o == $past(ev.status))
        else $error("status read mismatch");

    // input read shows the settled levels
    a_input_level: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && reg_rd_i && sel_input
        |=> reg_rdata_o[NUM_INPUTS-1:0] == $past(in_level))
        else $error("input levels not read back");

    // a zero written to a set flag keeps it
    a_status_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && ev.status[8] && !ev.clr_vec[8] |=> ev.status[8])
        else $error("flag lost without a one written");

    // no enabled flag standing means the output is released next edge
    a_no_spurious: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && !pending |=> general_event_out_n_o)
        else $error("output low without enabled flag");

    // clearing every standing flag drops them, then the output follows one edge later
    a_clear_drops: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && wr_status && (ev.status != 16'h0000)
        && ((reg_wdata_i & ev.status) == ev.status) && (set_vec == 16'h0000)
        |=> (ev.status == 16'h0000) ##1 (general_event_out_n_o || !clk_en_i || pending))
        else $error("clear did not release output");

    // the output never falls while routing is off, even with enabled flags standing
    a_route_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_reg)
        clk_en_i && pending && !event_routed |=> general_event_out_n_o)
        else $error("unrouted enabled event drove the output");
endmodule : gpev_core

// ### tb/gpev_term_model.sv
`timescale 1ns/1ps
// far side: input terminals and socket settings, each source flips on request
module gpev_term_model (
    // clock and one-cycle flip requests, one bit per source
    input  wire logic       sys_clk_i,
    input  wire logic [8:0] flip_i,
    // levels presented to the block
    output logic      [4:0] pins_o,
    output logic            video_o,
    output logic      [3:0] vcc_o,
    output logic      [3:0] vpp_o,
    output logic            vpp12_o
);
    // terminals start high, as if pulled up; settings start at zero
    initial begin
        pins_o  = 5'h1F;
        video_o = 1'b0;
        vcc_o   = 4'h0;
        vpp_o   = 4'h0;
        vpp12_o = 1'b0;
    end

    // a 12 V request also moves the vpp setting, as real software would
    always @(posedge sys_clk_i) begin
        pins_o   <= pins_o ^ flip_i[4:0];
        video_o  <= video_o ^ flip_i[5];
        vcc_o[0] <= vcc_o[0] ^ flip_i[6];
        vpp12_o  <= vpp12_o ^ flip_i[7];
        vpp_o    <= vpp_o ^ {2'b00, flip_i[7], flip_i[8]};
    end
endmodule : gpev_term_model

// ### tb/test_general_purpose_event_logic.sv
`timescale 1ns/1ps
module test_general_purpose_event_logic;
    import gpev_pkg::*;
    logic          sys_clk_i;   // 10 MHz clock
    logic          rst_n_i;     // active-low reset
    logic [7:0]    reg_addr_i;  // register offset
    gpev_word_type reg_wdata_i; // write data
    logic          reg_wr_i;    // write strobe
    logic          reg_rd_i;    // read strobe
    gpev_word_type reg_rdata_o; // read data
    logic          out_n;       // event output
    logic [8:0]    flip;        // flip requests to the model
    logic [4:0]    pins;        // terminal levels
    logic          video;       // video enable level
    logic [3:0]    vcc;         // supply setting
    logic [3:0]    vpp;         // programming setting
    logic          vpp12;       // 12 V request
    logic [4:0]    lvl;         // expected terminal levels
    logic [4:0]    m;           // random flip mask
    logic          rd_d;        // a read was taken last edge
    gpev_word_type exp_q[$];    // expected read data, oldest first
    int            n_errors;
    int            check_count;
    // status bit expected per source: pins 0-4, video, vcc, 12 V, other vpp
    localparam gpev_word_type SRC [9] = '{16'h0001, 16'h0002, 16'h0004,
        16'h0008, 16'h0010, 16'h8000, 16'h0800, 16'h0900, 16'h0800};

    gpev_core u_dut (
        .sys_clk_i            (sys_clk_i),
        .clk_en_i             (1'b1),
        .rst_n_i              (rst_n_i),
        .reg_addr_i           (reg_addr_i),
        .reg_wdata_i          (reg_wdata_i),
        .reg_wr_i             (reg_wr_i),
        .reg_rd_i             (reg_rd_i),
        .reg_rdata_o          (reg_rdata_o),
        .video_port_enable_i  (video),
        .socket_vcc_sel_i     (vcc),
        .socket_vpp_sel_i     (vpp),
        .vpp_is_12v_i         (vpp12),
        .input_pins_i         (pins),
        .general_event_out_n_o(out_n)
    );

    gpev_term_model u_term (
        .sys_clk_i(sys_clk_i),
        .flip_i   (flip),
        .pins_o   (pins),
        .video_o  (video),
        .vcc_o    (vcc),
        .vpp_o    (vpp),
        .vpp12_o  (vpp12)
    );

    // clock generator
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input gpev_word_type seen, input gpev_word_type exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // one-cycle strobes with an idle cycle after, so a strobe is never driven twice at one edge
    task automatic wr(input logic [7:0] a, input gpev_word_type d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input gpev_word_type e);
        exp_q.push_back(e);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : rd

    // output is looked at mid-cycle, once the edge's updates have landed
    task automatic chk_out(input logic e);
        @(negedge sys_clk_i);
        check({15'h0000, out_n}, {15'h0000, e});
        @(posedge sys_clk_i);
    endtask : chk_out

    task automatic flip_src(input logic [8:0] f);
        flip <= f;
        @(posedge sys_clk_i);
        flip <= 9'h000;
        repeat (7) @(posedge sys_clk_i);
    endtask : flip_src

    // read data stand only in the cycle after the read edge
    always @(posedge sys_clk_i) begin
        if (rd_d)
            check(reg_rdata_o, exp_q.pop_front());
        rd_d <= reg_rd_i;
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #(100 * 20000);
        n_errors++;
        summarize();
    end

    initial begin
        n_errors = 0;
        check_count = 0;
        rd_d = 1'b0;
        flip = 9'h000;
        reg_addr_i = 8'h00;
        reg_wdata_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        rst_n_i = 1'b0;
        lvl = 5'h1F;
        void'($urandom(32'h07c1_f673));
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        chk_out(1'b1);
        rd(8'hA8, 16'h0000);
        rd(8'hAA, 16'h0000);
        rd(8'hA7, 16'h0000);
        rd(8'hA0, 16'h0000);
        rd(8'hAC, 16'h001F);
        wr(8'hAA, 16'hFFFF);
        rd(8'hAA, 16'h891F);
        wr(8'hAA, 16'h0000);
        wr(8'hB8, 16'h801F);
        // every source sets its flag with the enables off, once per change
        for (int i = 0; i < 9; i++) begin
            flip_src(9'h001 << i);
            chk_out(1'b1);
            rd(8'hA8, SRC[i]);
            wr(8'hA8, SRC[i]);
            rd(8'hA8, 16'h0000);
        end
        // enabled: output falls, holds, and is released only by a one
        wr(8'hAA, 16'h891F);
        for (int i = 0; i < 9; i++) begin
            flip_src(9'h001 << i);
            chk_out(1'b0);
            repeat (20) @(posedge sys_clk_i);
            wr(8'hA8, ~SRC[i]);
            chk_out(1'b0);
            wr(8'hA8, SRC[i]);
            chk_out(1'b1);
        end
        // no event routing to a terminal
        wr(8'hB8, 16'h001F);
        flip_src(9'h020);
        chk_out(1'b1);
        wr(8'hA8, 16'h76E0);
        rd(8'hA8, 16'h8000);
        wr(8'hA8, 16'h8000);
        // terminal 0 not an input: flag still sets, no output
        wr(8'hB8, 16'h801E);
        flip_src(9'h001);
        chk_out(1'b1);
        rd(8'hA8, 16'h0001);
        wr(8'hA8, 16'h0001);
        wr(8'hB8, 16'h801F);
        lvl = lvl ^ 5'h01;
        // random groups of terminals changing together
        for (int k = 0; k < 8; k++) begin
            m = 5'($urandom % 31) + 5'h01;
            flip_src({4'h0, m});
            lvl = lvl ^ m;
            chk_out(1'b0);
            rd(8'hAC, {11'h000, lvl});
            rd(8'hA8, {11'h000, m});
            wr(8'hA8, {11'h000, m});
            chk_out(1'b1);
        end
        summarize();
    end
endmodule : test_general_purpose_event_logic
